// *** ulb_top.sv ***
`timescale 1ns/100ps
module ulb_top import ulb_pkg::*; (
   // Clock and reset
   input wire logic ref_clk,
   input wire logic rstn,
   // Register port
   input wire logic [31:0] addr,
   input wire logic [7:0] wr_data,
   input wire logic wr_stb,
   input wire logic rd_stb,
   output logic [7:0] rd_data,
   // Serial pins
   input wire logic serial_in_pin,
   output logic serial_out_pin
);
   logic [7:0] ctl0_q;
   logic [7:0] opt_q;
   logic [7:0] txh_q;
   logic [7:0] rxh_q;
   logic pwr;
   logic txe_on;
   logic rxe_on;
   logic dir;
   logic [1:0] ps;
   logic cl;
   logic wr_ctl;
   logic wr_opt;
   logic wr_str;
   logic wr_txh;
   logic rd_rxh;
   logic os_tick;
   logic stt_req;
   logic srt_arm;
   ulb_tx_st_t tx_st_q;
   logic [7:0] tsh_q;
   logic [3:0] os_q;
   logic [4:0] bit_q;
   logic line_q;
   logic tpar_q;
   logic pend_q;
   logic brk_pend_q;
   logic tsf_q;
   logic load;
   logic bit_end;
   logic stop_end;
   logic dbit;
   logic [4:0] brk_len;
   logic [2:0] sls;
   logic [7:0] tmask;
   logic txor;
   logic rx_line;
   logic rx_done;
   logic [7:0] rx_data;
   logic rx_perr;
   logic rx_ferr;
   logic rx_srf;
   logic rx_full_q;
   logic ovr;
   logic [2:0] err_q;
   logic [2:0] err_set;
   logic [8:0] brk_cnt_q;

   assign pwr = ctl0_q[C_PWR];
   assign txe_on = pwr & ctl0_q[C_TXE];
   assign rxe_on = pwr & ctl0_q[C_RXE];
   assign dir = ctl0_q[C_DIR];
   assign ps = ctl0_q[C_PS +: 2];
   assign cl = ctl0_q[C_CL];
   assign wr_ctl = wr_stb && addr == A_CTL0;
   assign wr_opt = wr_stb && addr == A_OPT0;
   assign wr_str = wr_stb && addr == A_STR;
   assign wr_txh = wr_stb && addr == A_TXH;
   assign rd_rxh = rd_stb && addr == A_RXH;
   assign stt_req = wr_opt & wr_data[O_STT] & txe_on;
   assign srt_arm = wr_opt & wr_data[O_SRT] & rxe_on & ~rx_srf;

   // ---------------------------------
   // Control registers
   // ---------------------------------
   always_ff @(posedge ref_clk) begin
      if (!rstn) begin
         ctl0_q <= CTL0_RST;
      end else if (wr_ctl) begin
         ctl0_q <= wr_data;
      end
   end

   always_ff @(posedge ref_clk) begin
      if (!rstn) begin
         opt_q <= OPT0_RST;
      end else if (wr_opt) begin
         opt_q <= wr_data & OPT0_RW_MASK;
      end
   end

   always_ff @(posedge ref_clk) begin
      if (!rstn) begin
         txh_q <= HOLD_RST;
      end else if (wr_txh) begin
         txh_q <= wr_data;
      end
   end

   ulb_baud u_baud (
      .ref_clk(ref_clk),
      .rstn(rstn),
      .run(pwr),
      .os_tick(os_tick)
   );

   // ---------------------------------
   // Transmitter
   // ---------------------------------
   assign sls = opt_q[O_SLS +: 3];
   assign brk_len = (sls >= BRK_WRAP) ? {2'h0, sls} + BRK_LO_BASE : {2'h0, sls} + BRK_HI_BASE;
   assign dbit = dir ? tsh_q[0] : tsh_q[7];
   assign bit_end = os_tick && os_q == OS_LAST;
   assign stop_end = tx_st_q == TX_STOP && bit_end && (bit_q != 5'h0 || !ctl0_q[C_SL]);
   // Leave idle only on a tick, so the first bit is a full bit time
   assign load = tx_st_q == TX_IDLE && pend_q && os_tick && !brk_pend_q && !stt_req;
   assign tmask = cl ? txh_q : (dir ? (txh_q & 8'h7f) : (txh_q & 8'hfe));
   assign txor = ^tmask;

   always_ff @(posedge ref_clk) begin
      if (!rstn || !txe_on) begin
         pend_q <= 1'b0;
      end else if (wr_txh) begin
         pend_q <= 1'b1;
      end else if (load) begin
         pend_q <= 1'b0;
      end
   end

   // Break request held until the next tick
   always_ff @(posedge ref_clk) begin
      if (!rstn || !txe_on) begin
         brk_pend_q <= 1'b0;
      end else if (stt_req && tx_st_q == TX_IDLE) begin
         brk_pend_q <= 1'b1;
      end else if (tx_st_q == TX_BRK) begin
         brk_pend_q <= 1'b0;
      end
   end

   always_ff @(posedge ref_clk) begin
      if (!rstn || !txe_on) begin
         tx_st_q <= TX_IDLE;
         tsh_q <= HOLD_RST;
         os_q <= 4'h0;
         bit_q <= 5'h0;
         line_q <= 1'b1;
         tpar_q <= 1'b0;
      end else begin
         case (tx_st_q)
            TX_IDLE: begin
               os_q <= 4'h0;
               bit_q <= 5'h0;
               if (os_tick && brk_pend_q) begin
                  tx_st_q <= TX_BRK;
                  line_q <= 1'b0;
               end else if (load) begin
                  tx_st_q <= TX_START;
                  tsh_q <= txh_q;
                  line_q <= 1'b0;
                  tpar_q <= (ps == PAR_ZERO) ? 1'b0 : txor ^ ~ps[0];
               end
            end
            TX_START: begin
               if (bit_end) begin
                  tx_st_q <= TX_DATA;
                  line_q <= dbit;
                  tsh_q <= dir ? tsh_q >> 1 : tsh_q << 1;
               end
            end
            TX_DATA: begin
               if (bit_end) begin
                  if (bit_q == (cl ? 5'h7 : 5'h6)) begin
                     bit_q <= 5'h0;
                     tx_st_q <= (ps != PAR_NONE) ? TX_PAR : TX_STOP;
                     line_q <= (ps != PAR_NONE) ? tpar_q : 1'b1;
                  end else begin
                     bit_q <= bit_q + 5'h1;
                     line_q <= dbit;
                     tsh_q <= dir ? tsh_q >> 1 : tsh_q << 1;
                  end
               end
            end
            TX_PAR: begin
               if (bit_end) begin
                  tx_st_q <= TX_STOP;
                  line_q <= 1'b1;
               end
            end
            TX_STOP: begin
               if (stop_end) begin
                  tx_st_q <= TX_IDLE;
               end else if (bit_end) begin
                  bit_q <= 5'h1;
               end
            end
            TX_BRK: begin
               if (bit_end && bit_q == brk_len - 5'h1) begin
                  tx_st_q <= TX_IDLE;
                  line_q <= 1'b1;
               end else if (bit_end) begin
                  bit_q <= bit_q + 5'h1;
               end
            end
            default: tx_st_q <= TX_IDLE;
         endcase
         if (tx_st_q != TX_IDLE) begin
            os_q <= bit_end ? 4'h0 : os_q + {3'h0, os_tick};
         end
      end
   end

   always_ff @(posedge ref_clk) begin
      if (!rstn || !txe_on) begin
         tsf_q <= 1'b0;
      end else if (wr_txh) begin
         tsf_q <= 1'b1;
      end else if (stop_end && !pend_q) begin
         tsf_q <= 1'b0;
      end
   end

   always_ff @(posedge ref_clk) begin
      if (!rstn) begin
         serial_out_pin <= 1'b1;
      end else begin
         serial_out_pin <= (pwr ? line_q : 1'b1) ^ opt_q[O_TDL];
      end
   end

   // ---------------------------------
   // Receiver
   // ---------------------------------
   assign rx_line = serial_in_pin ^ opt_q[O_RDL];

   ulb_rx u_rx (
      .ref_clk(ref_clk),
      .rstn(rstn),
      .en(rxe_on),
      .os_tick(os_tick),
      .rx_in(rx_line),
      .dir(dir),
      .ps(ps),
      .cl(cl),
      .arm(srt_arm),
      .done(rx_done),
      .data(rx_data),
      .perr(rx_perr),
      .ferr(rx_ferr),
      .srf(rx_srf)
   );

   assign ovr = rx_done && rx_full_q && !rd_rxh;

   always_ff @(posedge ref_clk) begin
      if (!rstn || !rxe_on) begin
         rx_full_q <= 1'b0;
      end else if (rx_done) begin
         rx_full_q <= 1'b1;
      end else if (rd_rxh) begin
         rx_full_q <= 1'b0;
      end
   end

   always_ff @(posedge ref_clk) begin
      if (!rstn || !pwr) begin
         rxh_q <= HOLD_RST;
      end else if (rx_done && !ovr) begin
         rxh_q <= rx_data;
      end
   end

   // ---------------------------------
   // Status flags
   // ---------------------------------
   assign err_set = {rx_done & rx_perr, rx_done & rx_ferr, ovr};

   for (genvar i = 0; i < 3; i++) begin : g_err
      always_ff @(posedge ref_clk) begin
         if (!rstn || !rxe_on) begin
            err_q[i] <= STR_ERR_RST[i];
         end else if (err_set[i]) begin
            err_q[i] <= 1'b1;
         end else if (wr_str && !wr_data[i]) begin
            err_q[i] <= 1'b0;
         end
      end
   end

   // ---------------------------------
   // Read port
   // ---------------------------------
   always_ff @(posedge ref_clk) begin
      if (!rstn || !rd_stb) begin
         rd_data <= 8'h00;
      end else begin
         case (addr)
            A_CTL0: rd_data <= ctl0_q;
            A_STR: rd_data <= {tsf_q, 4'h0, err_q};
            A_OPT0: rd_data <= {rx_srf, opt_q[6:0]};
            A_TXH: rd_data <= txh_q;
            A_RXH: rd_data <= rxh_q;
            default: rd_data <= 8'h00;
         endcase
      end
   end

   // ---------------------------------
   // Checks
   // ---------------------------------
   always_ff @(posedge ref_clk) begin
      if (!rstn || (tx_st_q != TX_BRK && tx_st_q != TX_STOP)) begin
         brk_cnt_q <= 9'h000;
      end else if (os_tick) begin
         brk_cnt_q <= brk_cnt_q + 9'h001;
      end
   end

   default clocking @(posedge ref_clk); endclocking
   default disable iff (!rstn);

   AST_PWR_OFF_PIN: assert property (!pwr |=> serial_out_pin == !$past(opt_q[O_TDL]))
      else $error("Pin not idle while power off");
   AST_TX_INVERT: assert property (pwr |=> serial_out_pin == ($past(line_q) ^ $past(opt_q[O_TDL])))
      else $error("Pin does not follow inversion");
   AST_BRK_WIDTH: assert property ($fell(tx_st_q == TX_BRK) && txe_on |-> brk_cnt_q == {brk_len, 4'h0})
      else $error("Break width wrong");
   AST_STOP_WIDTH: assert property ($fell(tx_st_q == TX_STOP) && txe_on |-> brk_cnt_q == (ctl0_q[C_SL] ? 9'h020 : 9'h010))
      else $error("Stop length wrong");
   AST_TRIG_READ0: assert property (rd_stb && addr == A_OPT0 |=> rd_data[O_SRT] == 1'b0 && rd_data[O_STT] == 1'b0)
      else $error("Trigger bits read nonzero");
   AST_TSF_SET: assert property (wr_txh && txe_on ##1 txe_on |-> tsf_q)
      else $error("Transfer flag not set");
   AST_TSF_OFF: assert property (!txe_on |=> !tsf_q)
      else $error("Transfer flag not cleared");
   AST_ERR_OFF: assert property (!rxe_on |=> err_q == 3'h0 && !rx_srf)
      else $error("Error flags not cleared");
   AST_ERR_W1_KEEP: assert property (wr_str && rxe_on && wr_data[2:0] == 3'h7 |=> (err_q & $past(err_q)) == $past(err_q))
      else $error("Error flag lost on write of one");
   AST_OVERRUN: assert property (ovr && rxe_on |=> err_q[S_OVE] && rxh_q == $past(rxh_q))
      else $error("Overrun not flagged or data not kept");
   AST_ZERO_PAR: assert property (rx_done && rx_perr |-> ps[1])
      else $error("Parity error without checking mode");
endmodule // ulb_top

// *** ulb_pkg.sv ***
package ulb_pkg;
   // ---------------------------------
   // Register byte addresses
   // ---------------------------------
   localparam logic [31:0] A_CTL0 = 32'hfffffa00;
   localparam logic [31:0] A_STR = 32'hfffffa04;
   localparam logic [31:0] A_OPT0 = 32'hfffffa08;
   localparam logic [31:0] A_TXH = 32'hfffffa0c;
   localparam logic [31:0] A_RXH = 32'hfffffa10;
   // ---------------------------------
   // Reset values and masks
   // ---------------------------------
   localparam logic [7:0] CTL0_RST = 8'h10;
   localparam logic [7:0] OPT0_RST = 8'h14;
   localparam logic [7:0] OPT0_RW_MASK = 8'h1f;
   localparam logic [2:0] STR_ERR_RST = 3'h0;
   localparam logic [7:0] HOLD_RST = 8'hff;
   // ---------------------------------
   // Field positions
   // ---------------------------------
   localparam int C_PWR = 7;
   localparam int C_TXE = 6;
   localparam int C_RXE = 5;
   localparam int C_DIR = 4;
   localparam int C_PS = 2;
   localparam int C_CL = 1;
   localparam int C_SL = 0;
   localparam int O_SRF = 7;
   localparam int O_SRT = 6;
   localparam int O_STT = 5;
   localparam int O_SLS = 2;
   localparam int O_TDL = 1;
   localparam int O_RDL = 0;
   localparam int S_TSF = 7;
   localparam int S_PE = 2;
   localparam int S_FE = 1;
   localparam int S_OVE = 0;
   // ---------------------------------
   // Parity modes
   // ---------------------------------
   localparam logic [1:0] PAR_NONE = 2'h0;
   localparam logic [1:0] PAR_ZERO = 2'h1;
   // ---------------------------------
   // Timing counts
   // ---------------------------------
   localparam logic [7:0] OS_DIV_M1 = 8'h03;
   localparam logic [3:0] OS_LAST = 4'hf;
   localparam logic [3:0] OS_MID = 4'h7;
   localparam logic [7:0] BRK_RX_MIN = 8'hb0;
   localparam logic [4:0] BRK_LO_BASE = 5'h08;
   localparam logic [4:0] BRK_HI_BASE = 5'h10;
   localparam logic [2:0] BRK_WRAP = 3'h5;
   // ---------------------------------
   // State types
   // ---------------------------------
   typedef enum logic [2:0] {TX_IDLE, TX_START, TX_DATA, TX_PAR, TX_STOP, TX_BRK} ulb_tx_st_t;
   typedef enum logic [1:0] {RX_IDLE, RX_START, RX_BITS, RX_STOP} ulb_rx_st_t;
endpackage

// *** ulb_baud.sv ***
`timescale 1ns/100ps
module ulb_baud import ulb_pkg::*; (
   // Clock and reset
   input wire logic ref_clk,
   input wire logic rstn,
   // Control
   input wire logic run,
   output logic os_tick
);
   logic [7:0] cnt_q;

   always_ff @(posedge ref_clk) begin
      if (!rstn || !run) begin
         cnt_q <= 8'h00;
         os_tick <= 1'b0;
      end else begin
         os_tick <= (cnt_q == OS_DIV_M1);
         cnt_q <= (cnt_q == OS_DIV_M1) ? 8'h00 : cnt_q + 8'h01;
      end
   end
endmodule // ulb_baud

// *** ulb_rx.sv ***
`timescale 1ns/100ps
module ulb_rx import ulb_pkg::*; (
   // Clock and reset
   input wire logic ref_clk,
   input wire logic rstn,
   // Control
   input wire logic en,
   input wire logic os_tick,
   input wire logic rx_in,
   input wire logic dir,
   input wire logic [1:0] ps,
   input wire logic cl,
   input wire logic arm,
   // Results
   output logic done,
   output logic [7:0] data,
   output logic perr,
   output logic ferr,
   output logic srf
);
   ulb_rx_st_t st_q;
   logic [3:0] os_q;
   logic [3:0] idx_q;
   logic [7:0] sh_q;
   logic par_q;
   logic [7:0] low_q;
   logic [3:0] nlast;
   logic haspar;
   logic x;

   assign nlast = cl ? 4'h7 : 4'h6;
   assign haspar = (ps != PAR_NONE);
   assign x = (^sh_q) ^ par_q;

   // ---------------------------------
   // Frame receiver
   // ---------------------------------
   always_ff @(posedge ref_clk) begin
      if (!rstn || !en) begin
         st_q <= RX_IDLE;
         os_q <= 4'h0;
         idx_q <= 4'h0;
         sh_q <= 8'h00;
         par_q <= 1'b0;
         done <= 1'b0;
         data <= HOLD_RST;
         perr <= 1'b0;
         ferr <= 1'b0;
      end else begin
         done <= 1'b0;
         case (st_q)
            RX_IDLE: begin
               if (!srf && !rx_in) begin
                  st_q <= RX_START;
                  os_q <= 4'h0;
               end
            end
            RX_START: begin
               if (os_tick && os_q == OS_MID) begin
                  st_q <= rx_in ? RX_IDLE : RX_BITS;
                  os_q <= 4'h0;
                  idx_q <= 4'h0;
                  sh_q <= 8'h00;
                  par_q <= 1'b0;
               end else if (os_tick) begin
                  os_q <= os_q + 4'h1;
               end
            end
            RX_BITS: begin
               if (os_tick && os_q == OS_LAST) begin
                  os_q <= 4'h0;
                  idx_q <= idx_q + 4'h1;
                  if (idx_q <= nlast) begin
                     if (dir) begin
                        sh_q[idx_q[2:0]] <= rx_in;
                     end else begin
                        sh_q[3'h7 - idx_q[2:0]] <= rx_in;
                     end
                  end else begin
                     par_q <= rx_in;
                  end
                  if ((idx_q == nlast && !haspar) || idx_q > nlast) begin
                     st_q <= RX_STOP;
                  end
               end else if (os_tick) begin
                  os_q <= os_q + 4'h1;
               end
            end
            RX_STOP: begin
               if (os_tick && os_q == OS_LAST) begin
                  st_q <= RX_IDLE;
                  done <= 1'b1;
                  data <= sh_q;
                  ferr <= !rx_in;
                  perr <= ps[1] & (x ^ ~ps[0]);
               end else if (os_tick) begin
                  os_q <= os_q + 4'h1;
               end
            end
            default: st_q <= RX_IDLE;
         endcase
      end
   end

   // ---------------------------------
   // Sync break detection
   // ---------------------------------
   always_ff @(posedge ref_clk) begin
      if (!rstn || !en) begin
         srf <= 1'b0;
         low_q <= 8'h00;
      end else if (arm) begin
         srf <= 1'b1;
         low_q <= 8'h00;
      end else if (srf && rx_in) begin
         low_q <= 8'h00;
         if (low_q >= BRK_RX_MIN) begin
            srf <= 1'b0;
         end
      end else if (srf && os_tick && low_q != 8'hff) begin
         low_q <= low_q + 8'h01;
      end
   end
endmodule // ulb_rx

// *** ulb_node.sv ***
`timescale 1ns/100ps
module ulb_node (
   // Clock
   input wire logic ref_clk,
   // Serial line
   input wire logic from_dut,
   output logic to_dut
);
   // -----------------------
   // Remote node
   // -----------------------
   localparam int BIT_CYC = 64;
   localparam int WAIT_MAX = 4000;

   initial to_dut = 1'b1;

   task automatic set_idle(input bit inv);
      @(posedge ref_clk);
      to_dut <= ~inv;
   endtask

   // Bit 0 of v goes first; line idles after the last bit
   task automatic send(input int v, input int n, input bit inv);
      for (int i = 0; i < n; i++) begin
         to_dut <= v[i] ^ inv;
         repeat (BIT_CYC) @(posedge ref_clk);
      end
      to_dut <= ~inv;
      @(posedge ref_clk);
   endtask

   // Samples each bit in its middle, start bit included
   task automatic grab(output logic [15:0] v, input int n, input bit inv, output bit ok);
      int k;
      v = '0;
      k = 0;
      while (from_dut !== inv && k < WAIT_MAX) begin
         @(posedge ref_clk);
         k++;
      end
      ok = k < WAIT_MAX;
      repeat (BIT_CYC / 2) @(posedge ref_clk);
      for (int i = 0; i < n; i++) begin
         v[i] = from_dut ^ inv;
         repeat (BIT_CYC) @(posedge ref_clk);
      end
   endtask

   task automatic low_width(output int w, output bit ok);
      int k;
      w = 0;
      k = 0;
      while (from_dut !== 1'b0 && k < 200) begin
         @(posedge ref_clk);
         k++;
      end
      while (from_dut === 1'b0 && w < WAIT_MAX) begin
         @(posedge ref_clk);
         w++;
      end
      ok = k < 200 && w < WAIT_MAX;
   endtask
endmodule // ulb_node

// *** testbench.sv ***
`timescale 1ns/100ps
module testbench import ulb_pkg::*; ;
   logic ref_clk, rstn, wr_stb, rd_stb, serial_in_pin, serial_out_pin;
   logic [31:0] addr;
   logic [7:0] wr_data, rd_data, ctl;
   logic [15:0] got;
   logic [6:0] cfg [8] = '{7'h12, 7'h0f, 7'h18, 7'h0d, 7'h7e, 7'h4a, 7'h2b, 7'h05};
   int err_total, comparisons, v, n, w, d;
   bit ok;

   ulb_top i_dut (.ref_clk(ref_clk), .rstn(rstn), .addr(addr), .wr_data(wr_data), .wr_stb(wr_stb),
      .rd_stb(rd_stb), .rd_data(rd_data), .serial_in_pin(serial_in_pin), .serial_out_pin(serial_out_pin));
   ulb_node i_node (.ref_clk(ref_clk), .from_dut(serial_out_pin), .to_dut(serial_in_pin));

   initial begin
      ref_clk = 1'b0;
      forever #5 ref_clk = ~ref_clk;
   end

   // -----------------------
   // Bus, checks, model
   // -----------------------
   task automatic wr(input logic [31:0] a, input logic [7:0] x);
      addr <= a;
      wr_data <= x;
      wr_stb <= 1'b1;
      @(posedge ref_clk);
      wr_stb <= 1'b0;
      @(posedge ref_clk);
   endtask

   task automatic rd(input logic [31:0] a, output logic [7:0] r);
      addr <= a;
      rd_stb <= 1'b1;
      @(posedge ref_clk);
      rd_stb <= 1'b0;
      @(posedge ref_clk);
      r = rd_data;
   endtask

   task automatic chk(input logic [15:0] g, input logic [15:0] e);
      comparisons++;
      if (g !== e) begin
         err_total++;
         $display("unexpected at %0t: got %h expected %h", $time, g, e);
      end
   endtask

   task automatic rchk(input logic [31:0] a, input logic [7:0] e);
      logic [7:0] r;
      rd(a, r);
      chk({8'h00, r}, {8'h00, e});
   endtask

   task automatic summarize;
      if (err_total == 0 && comparisons > 0)
         $display("No errors found");
      else
         $display("Errors were found");
      $finish;
   endtask

   task automatic wait_ok(input bit k);
      if (!k) begin
         err_total++;
         $display("unexpected at %0t: serial line wait ran out", $time);
         summarize();
      end
   endtask

   // Line bits of one frame, start bit at bit 0
   function automatic int mk_frame(input int x, input logic [7:0] c, output int nb);
      int p, b, f;
      f = 0;
      p = 0;
      nb = 1;
      for (int i = 0; i < (c[1] ? 8 : 7); i++) begin
         b = c[4] ? (x >> i) & 1 : (x >> (7 - i)) & 1;
         f |= b << nb;
         p ^= b;
         nb++;
      end
      if (c[3:2] != 2'h0) begin
         f |= (c[3:2] == 2'h3 ? p : c[3:2] == 2'h2 ? p ^ 1 : 0) << nb;
         nb++;
      end
      f |= (c[0] ? 3 : 1) << nb;
      nb += c[0] ? 2 : 1;
      return f;
   endfunction

   initial begin
      repeat (100000) @(posedge ref_clk);
      err_total++;
      summarize();
   end

   // -----------------------
   // Main sequence
   // -----------------------
   initial begin
      rstn = 1'b0;
      addr = '0;
      wr_data = '0;
      wr_stb = 1'b0;
      rd_stb = 1'b0;
      void'($urandom(32'hd78b));
      repeat (4) @(posedge ref_clk);
      rstn <= 1'b1;
      @(posedge ref_clk);
      rchk(A_CTL0, CTL0_RST);
      rchk(A_STR, 8'h00);
      rchk(A_OPT0, 8'h14);
      rchk(A_TXH, 8'hff);
      rchk(A_RXH, 8'hff);
      rchk(32'hfffffa14, 8'h00);
      ctl = 8'h80;
      wr(A_CTL0, ctl);
      foreach (cfg[i]) begin
         wr(A_CTL0, ctl & 8'h9f);
         ctl = 8'h80 | cfg[i][4:0];
         wr(A_CTL0, ctl);
         wr(A_OPT0, 8'h14 | cfg[i][6:5]);
         i_node.set_idle(cfg[i][5]);
         ctl = ctl | 8'h60;
         wr(A_CTL0, ctl);
         d = $urandom & 8'hff;
         v = mk_frame(d, ctl, n);
         fork
            i_node.grab(got, n, cfg[i][6], ok);
            i_node.send(v, n, cfg[i][5]);
            begin
               wr(A_TXH, d[7:0]);
               rchk(A_STR, 8'h80);
            end
         join
         wait_ok(ok);
         chk(got, v[15:0]);
         rchk(A_RXH, ctl[1] ? d[7:0] : ctl[4] ? d[7:0] & 8'h7f : d[7:0] & 8'hfe);
         rchk(A_STR, 8'h00);
      end
      wr(A_CTL0, ctl & 8'h9f);
      wr(A_OPT0, 8'h14);
      i_node.set_idle(1'b0);
      ctl = 8'hfe;
      wr(A_CTL0, ctl);
      d = $urandom & 8'hff;
      v = mk_frame(d, ctl, n);
      i_node.send(v ^ 32'h200, n, 1'b0);
      rchk(A_RXH, d[7:0]);
      rchk(A_STR, 8'h04);
      wr(A_STR, 8'hff);
      rchk(A_STR, 8'h04);
      wr(A_STR, 8'h00);
      rchk(A_STR, 8'h00);
      i_node.send(v ^ 32'h400, n, 1'b0);
      rchk(A_RXH, d[7:0]);
      rchk(A_STR, 8'h02);
      wr(A_STR, 8'h00);
      // Low stop bit may have opened a false frame
      wr(A_CTL0, 8'hde);
      wr(A_CTL0, ctl);
      i_node.send(v, n, 1'b0);
      i_node.send(v ^ 32'h006, n, 1'b0);
      rchk(A_STR, 8'h01);
      rchk(A_RXH, d[7:0]);
      wr(A_CTL0, 8'hde);
      rchk(A_STR, 8'h00);
      wr(A_CTL0, ctl);
      wr(A_OPT0, 8'h54);
      rchk(A_OPT0, 8'h94);
      i_node.send(0, 5, 1'b0);
      rchk(A_OPT0, 8'h94);
      i_node.send(0, 12, 1'b0);
      repeat (4) @(posedge ref_clk);
      rchk(A_OPT0, 8'h14);
      for (int i = 0; i < 8; i++) begin
         wr(A_CTL0, 8'hbe);
         wr(A_OPT0, 8'(i << 2));
         wr(A_CTL0, ctl);
         fork
            i_node.low_width(w, ok);
            wr(A_OPT0, 8'(i << 2) | 8'h20);
         join
         wait_ok(ok);
         chk(16'(w), 16'((((i + 3) % 8) + 13) * 64));
         rchk(A_OPT0, 8'(i << 2));
      end
      wr(A_CTL0, 8'h9e);
      wr(A_CTL0, 8'h1e);
      wr(A_OPT0, 8'h16);
      repeat (3) @(posedge ref_clk);
      chk({15'h0, serial_out_pin}, 16'h0000);
      rchk(A_RXH, 8'hff);
      rchk(A_STR, 8'h00);
      wr(A_OPT0, 8'h14);
      repeat (3) @(posedge ref_clk);
      chk({15'h0, serial_out_pin}, 16'h0001);
      summarize();
   end
endmodule // testbench
